// ---- core/pcims_sequencer.sv ----
// Purpose: PCI initiator that turns a stream of test commands into bus transactions.
// Assumes: Bus pins are synchronous to ref_clk_i, so they are sampled without synchronisers.
// Notes: 64-bit commands assume the target accepts the 64-bit extension.
`timescale 1ns/100ps
`default_nettype none
module pcims_sequencer
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Command stream
    input wire logic cmd_valid_i,
    input wire pcims_pkg::pcims_cmd_t cmd_i,
    output logic cmd_ready_o,
    // Completion and read data
    output logic done_o,
    output pcims_pkg::pcims_term_t term_o,
    output logic [pcims_pkg::CNT_W-1:0] moved_o,
    output logic rd_valid_o,
    output logic [63:0] rd_data_o,
    // Arbitration
    output logic req_n_o,
    input wire logic gnt_n_i,
    // Address, data and byte enables
    input wire logic [63:0] ad_i,
    output logic [63:0] ad_o,
    output logic ad_lo_oe_o,
    output logic ad_hi_oe_o,
    output logic [7:0] cbe_o,
    output logic cbe_oe_o,
    // Control pins
    input wire logic frame_n_i,
    output logic frame_n_o,
    input wire logic irdy_n_i,
    output logic irdy_n_o,
    output logic ctl_oe_o,
    output logic req64_n_o,
    input wire logic trdy_n_i,
    input wire logic devsel_n_i,
    input wire logic stop_n_i
);

    typedef enum logic [2:0] {
        S_IDLE,
        S_REQ,
        S_ADDR,
        S_DATA,
        S_TURN
    } pcims_state_t;

    pcims_state_t state_reg;
    pcims_pkg::pcims_cmd_t cur_reg;
    logic [63:0] beat_data;
    logic beat_last;
    logic beat_last2;
    logic [2:0] mab_cnt_reg;
    logic claimed_reg;
    logic term_valid_reg;
    logic wr_cmd;
    logic wide_cmd;
    logic grant_ok;
    logic xfer;
    logic stop_seen;
    logic abort_cond;
    logic end_req;
    logic finish;

    assign wr_cmd = pcims_pkg::is_write(cur_reg.op);
    assign wide_cmd = pcims_pkg::is_wide(cur_reg.op);
    // The bus is taken only when granted and the previous owner has let it go idle.
    assign grant_ok = state_reg == S_REQ && !gnt_n_i && frame_n_i && irdy_n_i;
    assign xfer = state_reg == S_DATA && !trdy_n_i && !devsel_n_i;
    assign stop_seen = state_reg == S_DATA && !stop_n_i;
    assign abort_cond = state_reg == S_DATA && !claimed_reg && devsel_n_i &&
        mab_cnt_reg >= pcims_pkg::MABORT_CLKS;
    assign end_req = (xfer && beat_last) || stop_seen || abort_cond || term_valid_reg;
    // FRAME# must already be high, so the phase in progress is the final one.
    assign finish = state_reg == S_DATA && end_req && frame_n_o;
    assign cmd_ready_o = state_reg == S_IDLE;

    pcims_beat_gen u_beat
    (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .load_i(state_reg == S_REQ),
        .step_i(xfer),
        .wide_i(wide_cmd),
        .seed_i(cur_reg.data),
        .count_i(cur_reg.count),
        .data_o(beat_data),
        .left_o(),
        .moved_o(moved_o),
        .last_o(beat_last),
        .last2_o(beat_last2)
    );

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= S_IDLE;
            cur_reg <= '0;
        end
        else
        begin
            case (state_reg)
                S_IDLE:
                begin
                    if (cmd_valid_i)
                    begin
                        cur_reg <= cmd_i;
                        // Only memory commands may burst; the others always move one phase.
                        if (!(cmd_i.op inside {pcims_pkg::OP_MEM_WR32, pcims_pkg::OP_MEM_RD32,
                            pcims_pkg::OP_MEM_WR64, pcims_pkg::OP_MEM_RD64}))
                            cur_reg.count <= pcims_pkg::COUNT_ONE;
                        state_reg <= S_REQ;
                    end
                end
                S_REQ:
                begin
                    if (grant_ok)
                        state_reg <= S_ADDR;
                end
                S_ADDR: state_reg <= S_DATA;
                S_DATA:
                begin
                    if (finish)
                        state_reg <= S_TURN;
                end
                S_TURN: state_reg <= S_IDLE;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // FRAME# rises for the last data phase, so a count of one never bursts.
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            frame_n_o <= 1'b1;
        else if (grant_ok)
            frame_n_o <= 1'b0;
        else if (state_reg == S_ADDR)
            frame_n_o <= beat_last;
        else if (state_reg == S_DATA && (end_req || (xfer && beat_last2)))
            frame_n_o <= 1'b1;
        else if (state_reg == S_TURN)
            frame_n_o <= 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            req64_n_o <= 1'b1;
        else if (grant_ok)
            req64_n_o <= !pcims_pkg::is_wide(cur_reg.op);
        else if (state_reg == S_ADDR)
            req64_n_o <= !wide_cmd || beat_last;
        else if (state_reg == S_DATA && (end_req || (xfer && beat_last2)))
            req64_n_o <= 1'b1;
        else if (state_reg == S_TURN)
            req64_n_o <= 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            irdy_n_o <= 1'b1;
        else if (state_reg == S_ADDR)
            irdy_n_o <= 1'b0;
        else if (finish)
            irdy_n_o <= 1'b1;
    end

    // Control pins stay driven through the turnaround cycle so they are left high, not floating.
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            ctl_oe_o <= 1'b0;
        else if (grant_ok)
            ctl_oe_o <= 1'b1;
        else if (state_reg == S_TURN)
            ctl_oe_o <= 1'b0;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            req_n_o <= 1'b1;
        else if (state_reg == S_IDLE && cmd_valid_i)
            req_n_o <= 1'b0;
        else if (state_reg == S_ADDR)
            req_n_o <= 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i || state_reg == S_ADDR)
            mab_cnt_reg <= 3'h0;
        else if (state_reg == S_DATA && mab_cnt_reg < pcims_pkg::MABORT_CLKS)
            mab_cnt_reg <= mab_cnt_reg + 3'h1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i || state_reg == S_ADDR)
            claimed_reg <= 1'b0;
        else if (state_reg == S_DATA && !devsel_n_i)
            claimed_reg <= 1'b1;
    end

    // The first terminating event decides the reported reason.
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            term_valid_reg <= 1'b0;
            term_o <= pcims_pkg::TERM_OK;
        end
        else if (state_reg == S_ADDR)
            term_valid_reg <= 1'b0;
        else if (state_reg == S_DATA && !term_valid_reg && end_req)
        begin
            term_valid_reg <= 1'b1;
            if (abort_cond)
                term_o <= pcims_pkg::TERM_MABORT;
            else if (stop_seen && devsel_n_i)
                term_o <= pcims_pkg::TERM_TABORT;
            else if (stop_seen && !xfer && moved_o == pcims_pkg::COUNT_ZERO)
                term_o <= pcims_pkg::TERM_RETRY;
            else if (stop_seen)
                term_o <= pcims_pkg::TERM_DISC;
            else
                term_o <= pcims_pkg::TERM_OK;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            done_o <= 1'b0;
        else
            done_o <= state_reg == S_TURN;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            rd_valid_o <= 1'b0;
            rd_data_o <= 64'h0000000000000000;
        end
        else
        begin
            rd_valid_o <= xfer && !wr_cmd;
            if (xfer && !wr_cmd)
                rd_data_o <= wide_cmd ? ad_i : {32'h00000000, ad_i[31:0]};
        end
    end

    // Both pin groups are muxed from registered state only.
    assign ad_o = (state_reg == S_ADDR) ? {32'h00000000, cur_reg.addr} : beat_data;
    assign ad_lo_oe_o = state_reg == S_ADDR || (state_reg == S_DATA && wr_cmd);
    assign ad_hi_oe_o = state_reg == S_DATA && wr_cmd && wide_cmd;
    assign cbe_oe_o = ctl_oe_o && state_reg != S_TURN;
    assign cbe_o = (state_reg == S_ADDR) ? {4'h0, pcims_pkg::bus_code(cur_reg.op)} :
        {pcims_pkg::BE_ALL, (cur_reg.op == pcims_pkg::OP_CFG_WR) ? cur_reg.be : pcims_pkg::BE_ALL};

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_cfg_rd_cmd: assert property ($fell(frame_n_o) && cur_reg.op == pcims_pkg::OP_CFG_RD |->
        cbe_o[3:0] == pcims_pkg::BUS_CFG_RD && ad_o[31:0] == cur_reg.addr ##1 frame_n_o)
        else $error("config read not a single phase at the command address");
    chk_cfg_wr_data: assert property (state_reg == S_DATA && cur_reg.op == pcims_pkg::OP_CFG_WR |->
        cbe_o[3:0] == cur_reg.be && ad_o[31:0] == cur_reg.data[31:0] && ad_lo_oe_o)
        else $error("config write data phase wrong");
    chk_single_phase: assert property ($fell(frame_n_o) && cur_reg.count <= pcims_pkg::COUNT_ONE
        |=> frame_n_o && !irdy_n_o)
        else $error("single command did not end frame at first data phase");
    chk_burst_frame: assert property ($fell(frame_n_o) && cur_reg.count > pcims_pkg::COUNT_ONE
        |=> !frame_n_o)
        else $error("burst released frame in first data phase");
    chk_wr_first: assert property ($past(state_reg) == S_ADDR && state_reg == S_DATA && wr_cmd
        |-> ad_o == (wide_cmd ? cur_reg.data : {32'h00000000, cur_reg.data[31:0]}))
        else $error("first write data phase not the command data");
    chk_wr_incr: assert property (xfer && wr_cmd && !beat_last |=>
        (wide_cmd ? ad_o == $past(ad_o) + 64'h1 : ad_o[31:0] == $past(ad_o[31:0]) + 32'h1))
        else $error("burst write data did not step by one");
    chk_rd_capture: assert property (xfer && !wr_cmd |=> rd_valid_o &&
        rd_data_o[31:0] == $past(ad_i[31:0]))
        else $error("read phase data not delivered");
    chk_wide_req: assert property ($fell(frame_n_o) |-> req64_n_o == !wide_cmd)
        else $error("64-bit request line wrong at address phase");
    chk_io_rd_cmd: assert property ($fell(frame_n_o) && cur_reg.op == pcims_pkg::OP_IO_RD |->
        cbe_o[3:0] == pcims_pkg::BUS_IO_RD ##1 frame_n_o)
        else $error("I/O read not a single phase with the I/O read code");
    chk_io_wr_cmd: assert property ($fell(frame_n_o) && cur_reg.op == pcims_pkg::OP_IO_WR |->
        ad_o[31:0] == cur_reg.addr ##1 frame_n_o)
        else $error("I/O write not a single phase at the command address");
    chk_stop_end: assert property (stop_seen |-> ##[1:2] frame_n_o ##[0:1] state_reg == S_TURN)
        else $error("stop did not end the transaction");
    chk_mabort_end: assert property (abort_cond |-> ##[1:2] (done_o && term_o == pcims_pkg::TERM_MABORT)
        or ##[2:3] (done_o && term_o == pcims_pkg::TERM_MABORT))
        else $error("unclaimed transaction not master aborted");
    chk_in_order: assert property ($rose(cmd_ready_o) |-> $past(state_reg) == S_TURN &&
        $past(frame_n_o) && $past(irdy_n_o) && !ctl_oe_o)
        else $error("next command taken before bus release");

    cov_burst_write: cover property (xfer && wr_cmd && !beat_last ##1 xfer ##[1:8] done_o);
    cov_master_abort: cover property (done_o && term_o == pcims_pkg::TERM_MABORT);
    cov_retry: cover property (done_o && term_o == pcims_pkg::TERM_RETRY);
    cov_wide_read: cover property (xfer && wide_cmd && !wr_cmd);

endmodule
`default_nettype wire

// ---- core/pcims_pkg.sv ----
// Purpose: Shared types, bus codes and decode helpers for the PCI master command sequencer.
// Assumes: PCI bus synchronous to ref_clk_i; one command in flight at a time.
// Notes: Counts of zero are handled as one by the beat generator.
package pcims_pkg;

    typedef enum logic [2:0] {
        OP_CFG_RD,
        OP_CFG_WR,
        OP_MEM_WR32,
        OP_MEM_RD32,
        OP_MEM_WR64,
        OP_MEM_RD64,
        OP_IO_RD,
        OP_IO_WR
    } pcims_op_t;

    typedef enum logic [2:0] {
        TERM_OK,
        TERM_RETRY,
        TERM_DISC,
        TERM_TABORT,
        TERM_MABORT
    } pcims_term_t;

    localparam int CNT_W = 16;

    typedef struct packed {
        pcims_op_t op;
        logic [31:0] addr;
        logic [63:0] data;
        logic [3:0] be;
        logic [CNT_W-1:0] count;
    } pcims_cmd_t;

    // PCI bus command codes driven on the low C/BE lanes in the address phase; BE_ALL enables every byte lane in data phases.
    localparam logic [3:0] BUS_IO_RD = 4'h2;
    localparam logic [3:0] BUS_IO_WR = 4'h3;
    localparam logic [3:0] BUS_MEM_RD = 4'h6;
    localparam logic [3:0] BUS_MEM_WR = 4'h7;
    localparam logic [3:0] BUS_CFG_RD = 4'hA;
    localparam logic [3:0] BUS_CFG_WR = 4'hB;
    localparam logic [3:0] BE_ALL = 4'h0;

    localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] COUNT_TWO = 16'h0002;

    // Clocks after the address phase that a target has to assert DEVSEL#.
    localparam logic [2:0] MABORT_CLKS = 3'h4;

    function automatic logic is_write(input pcims_op_t op);
        return op == OP_CFG_WR || op == OP_MEM_WR32 || op == OP_MEM_WR64 || op == OP_IO_WR;
    endfunction

    function automatic logic is_wide(input pcims_op_t op);
        return op == OP_MEM_WR64 || op == OP_MEM_RD64;
    endfunction

    function automatic logic [3:0] bus_code(input pcims_op_t op);
        case (op)
            OP_CFG_RD: return BUS_CFG_RD;
            OP_CFG_WR: return BUS_CFG_WR;
            OP_MEM_WR32, OP_MEM_WR64: return BUS_MEM_WR;
            OP_MEM_RD32, OP_MEM_RD64: return BUS_MEM_RD;
            OP_IO_RD: return BUS_IO_RD;
            default: return BUS_IO_WR;
        endcase
    endfunction

endpackage

// ---- core/pcims_beat_gen.sv ----
// Purpose: Data phase counter and auto-incrementing write data for one transaction.
// Assumes: load_i and step_i never coincide.
// Notes: A 32-bit burst wraps within the low doubleword and clears the high half on every step.
`timescale 1ns/100ps
`default_nettype none
module pcims_beat_gen
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic load_i,
    input wire logic step_i,
    input wire logic wide_i,
    input wire logic [63:0] seed_i,
    input wire logic [pcims_pkg::CNT_W-1:0] count_i,
    // State
    output logic [63:0] data_o,
    output logic [pcims_pkg::CNT_W-1:0] left_o,
    output logic [pcims_pkg::CNT_W-1:0] moved_o,
    output logic last_o,
    output logic last2_o
);

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            data_o <= 64'h0000000000000000;
        else if (load_i)
            data_o <= seed_i;
        else if (step_i && wide_i)
            data_o <= data_o + 64'h0000000000000001;
        else if (step_i)
            data_o <= {32'h00000000, data_o[31:0] + 32'h00000001};
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            left_o <= pcims_pkg::COUNT_ONE;
        else if (load_i)
            left_o <= (count_i == pcims_pkg::COUNT_ZERO) ? pcims_pkg::COUNT_ONE : count_i;
        else if (step_i && left_o != pcims_pkg::COUNT_ONE)
            left_o <= left_o - pcims_pkg::COUNT_ONE;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i || load_i)
            moved_o <= pcims_pkg::COUNT_ZERO;
        else if (step_i)
            moved_o <= moved_o + pcims_pkg::COUNT_ONE;
    end

    assign last_o = left_o == pcims_pkg::COUNT_ONE;
    assign last2_o = left_o == pcims_pkg::COUNT_TWO;

endmodule
`default_nettype wire

// ---- tb/pcims_tgt_model.sv ----
// Purpose: Behavioural target agent that answers the sequencer on the shared bus.
// Assumes: Bus pins are synchronous to ref_clk_i; the bench picks the answer per transaction.
// Notes: Read data depends only on the beat number, so the bench can predict every phase.
`timescale 1ns/100ps
`default_nettype none
module pcims_tgt_model
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Answer chosen by the bench
    input wire pcims_pkg::pcims_term_t mode_i,
    input wire logic slow_i,
    // Bus
    input wire logic frame_n_i,
    input wire logic irdy_n_i,
    input wire logic [63:0] ad_i,
    input wire logic [7:0] cbe_i,
    output logic devsel_n_o,
    output logic trdy_n_o,
    output logic stop_n_o,
    output logic [63:0] rd_o,
    output logic rd_oe_o
);
    logic act_reg, frame_d_reg, xfer, ok_mode;
    logic [3:0] code_reg, be_reg;
    logic [31:0] addr_reg;
    logic [15:0] beats_reg;
    int addr_count_reg;
    logic [63:0] wlog [0:15];

    assign xfer = act_reg && !irdy_n_i && !trdy_n_o;
    assign ok_mode = mode_i == pcims_pkg::TERM_OK || mode_i == pcims_pkg::TERM_DISC;
    assign rd_o = {16'h1000, beats_reg, 16'h2000, beats_reg};
    assign rd_oe_o = act_reg && !code_reg[0];

    always_ff @(posedge ref_clk_i)
    begin
        frame_d_reg <= frame_n_i;
        if (!reset_n_i)
        begin
            act_reg <= 1'b0;
            devsel_n_o <= 1'b1;
            trdy_n_o <= 1'b1;
            stop_n_o <= 1'b1;
            addr_count_reg <= 0;
        end
        else if (frame_d_reg && !frame_n_i && !act_reg)
        begin
            // A master abort is modelled by never claiming the address.
            addr_count_reg <= addr_count_reg + 1;
            code_reg <= cbe_i[3:0];
            addr_reg <= ad_i[31:0];
            beats_reg <= 16'h0000;
            act_reg <= mode_i != pcims_pkg::TERM_MABORT;
            devsel_n_o <= mode_i == pcims_pkg::TERM_MABORT || mode_i == pcims_pkg::TERM_TABORT;
            trdy_n_o <= !ok_mode || slow_i;
            stop_n_o <= mode_i == pcims_pkg::TERM_OK || mode_i == pcims_pkg::TERM_MABORT;
        end
        else if (act_reg)
        begin
            if (xfer)
            begin
                wlog[beats_reg[3:0]] <= ad_i;
                be_reg <= cbe_i[3:0];
                beats_reg <= beats_reg + 16'h0001;
            end
            if (frame_n_i && (irdy_n_i || xfer || !stop_n_o))
            begin
                act_reg <= 1'b0;
                devsel_n_o <= 1'b1;
                trdy_n_o <= 1'b1;
                stop_n_o <= 1'b1;
            end
            else
            begin
                // A disconnect moves one beat only, then waits for the master to finish.
                trdy_n_o <= (slow_i && !trdy_n_o) || !ok_mode || (xfer && !stop_n_o);
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/pcims_sequencer_tb.sv ----
// Purpose: Self-checking bench for the command sequencer against a target model.
// Assumes: Grant follows request one cycle later; unclaimed bus lines float high.
// Notes: Inputs change at rising edges, outputs are sampled at falling edges.
`timescale 1ns/100ps
`default_nettype none
module pcims_sequencer_tb;
    logic ref_clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, gnt_n = 1'b1, tslow = 1'b0;
    pcims_pkg::pcims_cmd_t cmd = '0;
    pcims_pkg::pcims_term_t tmode = pcims_pkg::TERM_OK, term_o;
    logic cmd_ready, done, rd_valid, req_n, lo_oe, hi_oe, cbe_oe, frame_n, irdy_n, ctl_oe;
    logic devsel_n, trdy_n, stop_n, rd_oe, frame_bus, irdy_bus;
    logic [15:0] moved;
    logic [7:0] cbe;
    logic [63:0] rd_data, ad_o, ad_bus, rd;
    logic [63:0] rq [$];
    int n_fail = 0, n_compared = 0;

    always #5 ref_clk = ~ref_clk;
    always_ff @(posedge ref_clk) gnt_n <= req_n;
    always @(negedge ref_clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
    assign ad_bus[31:0] = lo_oe ? ad_o[31:0] : (rd_oe ? rd[31:0] : 32'hFFFF_FFFF);
    assign ad_bus[63:32] = hi_oe ? ad_o[63:32] : (rd_oe ? rd[63:32] : 32'hFFFF_FFFF);
    assign frame_bus = ctl_oe ? frame_n : 1'b1;
    assign irdy_bus = ctl_oe ? irdy_n : 1'b1;

    pcims_sequencer pcims_sequencer_inst (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(cmd_ready), .done_o(done),
        .term_o(term_o), .moved_o(moved), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
        .req_n_o(req_n), .gnt_n_i(gnt_n), .ad_i(ad_bus), .ad_o(ad_o), .ad_lo_oe_o(lo_oe),
        .ad_hi_oe_o(hi_oe), .cbe_o(cbe), .cbe_oe_o(cbe_oe), .frame_n_i(frame_bus),
        .frame_n_o(frame_n), .irdy_n_i(irdy_bus), .irdy_n_o(irdy_n), .ctl_oe_o(ctl_oe),
        .req64_n_o(), .trdy_n_i(trdy_n), .devsel_n_i(devsel_n), .stop_n_i(stop_n));
    pcims_tgt_model pcims_tgt_model_inst (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .mode_i(tmode), .slow_i(tslow), .frame_n_i(frame_bus), .irdy_n_i(irdy_bus),
        .ad_i(ad_bus), .cbe_i(cbe_oe ? cbe : 8'hFF), .devsel_n_o(devsel_n), .trdy_n_o(trdy_n),
        .stop_n_o(stop_n), .rd_o(rd), .rd_oe_o(rd_oe));

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic run_cmd(input pcims_pkg::pcims_op_t op, input logic [31:0] a,
        input logic [63:0] d, input logic [3:0] be, input logic [15:0] cnt,
        input pcims_pkg::pcims_term_t mode, input logic slow, input logic [3:0] code,
        input pcims_pkg::pcims_term_t term, input logic [15:0] mv);
        int k;
        int n0;
        n0 = pcims_tgt_model_inst.addr_count_reg;
        rq.delete();
        @(posedge ref_clk);
        tmode <= mode;
        tslow <= slow;
        cmd <= '{op, a, d, be, cnt};
        cmd_valid <= 1'b1;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        @(negedge ref_clk);
        check("ready while busy", 64'h0, 64'(cmd_ready));
        k = 0;
        while (done !== 1'b1 && k < 100)
        begin
            @(negedge ref_clk);
            k++;
        end
        check("done", 64'h1, 64'(done));
        check("term", 64'(term), 64'(term_o));
        check("moved", 64'(mv), 64'(moved));
        check("bus code", 64'(code), 64'(pcims_tgt_model_inst.code_reg));
        check("address", 64'(a), 64'(pcims_tgt_model_inst.addr_reg));
        check("address phases", 64'(n0 + 1), 64'(pcims_tgt_model_inst.addr_count_reg));
    endtask

    task automatic chk_writes(input int n, input logic [63:0] d, input logic wide);
        for (int i = 0; i < n; i++)
        begin
            if (wide)
                check("wide write data", d + 64'(i), pcims_tgt_model_inst.wlog[i]);
            else
                check("write data", {32'h0, d[31:0] + 32'(i)},
                    {32'h0, pcims_tgt_model_inst.wlog[i][31:0]});
        end
    endtask

    task automatic chk_reads(input int n, input logic wide);
        check("read beats", 64'(n), 64'(rq.size()));
        for (int i = 0; i < n && i < rq.size(); i++)
            check("read data", {wide ? 16'h1000 : 16'h0, wide ? 16'(i) : 16'h0, 16'h2000,
                16'(i)}, rq[i]);
    endtask

    task automatic t_config;
        run_cmd(pcims_pkg::OP_CFG_RD, 32'h0000_0010, 64'h0, 4'h0, 16'h3, pcims_pkg::TERM_OK,
            1'b0, pcims_pkg::BUS_CFG_RD, pcims_pkg::TERM_OK, 16'h1);
        chk_reads(1, 1'b0);
        run_cmd(pcims_pkg::OP_CFG_WR, 32'h0000_0004, 64'h147, 4'h5, 16'h1, pcims_pkg::TERM_OK,
            1'b0, pcims_pkg::BUS_CFG_WR, pcims_pkg::TERM_OK, 16'h1);
        chk_writes(1, 64'h147, 1'b0);
        check("byte enables", 64'h5, 64'(pcims_tgt_model_inst.be_reg));
        $display("test config finished");
    endtask

    task automatic t_mem32;
        run_cmd(pcims_pkg::OP_MEM_WR32, 32'h0000_0100, 64'hCAFE_0001, 4'h0, 16'h1,
            pcims_pkg::TERM_OK, 1'b0, pcims_pkg::BUS_MEM_WR, pcims_pkg::TERM_OK, 16'h1);
        chk_writes(1, 64'hCAFE_0001, 1'b0);
        run_cmd(pcims_pkg::OP_MEM_WR32, 32'h0000_0200, 64'hFFFF_FFFE, 4'h0, 16'h4,
            pcims_pkg::TERM_OK, 1'b1, pcims_pkg::BUS_MEM_WR, pcims_pkg::TERM_OK, 16'h4);
        chk_writes(4, 64'hFFFF_FFFE, 1'b0);
        run_cmd(pcims_pkg::OP_MEM_RD32, 32'h0000_0300, 64'h0, 4'h0, 16'h1,
            pcims_pkg::TERM_OK, 1'b0, pcims_pkg::BUS_MEM_RD, pcims_pkg::TERM_OK, 16'h1);
        chk_reads(1, 1'b0);
        run_cmd(pcims_pkg::OP_MEM_RD32, 32'h0000_0304, 64'h0, 4'h0, 16'h3,
            pcims_pkg::TERM_OK, 1'b0, pcims_pkg::BUS_MEM_RD, pcims_pkg::TERM_OK, 16'h3);
        chk_reads(3, 1'b0);
        $display("test mem32 finished");
    endtask

    task automatic t_mem64;
        run_cmd(pcims_pkg::OP_MEM_WR64, 32'h0000_0400, 64'h1234_5678_9ABC_DEF0, 4'h0, 16'h1,
            pcims_pkg::TERM_OK, 1'b0, pcims_pkg::BUS_MEM_WR, pcims_pkg::TERM_OK, 16'h1);
        chk_writes(1, 64'h1234_5678_9ABC_DEF0, 1'b1);
        run_cmd(pcims_pkg::OP_MEM_WR64, 32'h0000_0408, 64'h0000_0001_FFFF_FFFF, 4'h0, 16'h3,
            pcims_pkg::TERM_OK, 1'b0, pcims_pkg::BUS_MEM_WR, pcims_pkg::TERM_OK, 16'h3);
        chk_writes(3, 64'h0000_0001_FFFF_FFFF, 1'b1);
        run_cmd(pcims_pkg::OP_MEM_RD64, 32'h0000_0500, 64'h0, 4'h0, 16'h1,
            pcims_pkg::TERM_OK, 1'b0, pcims_pkg::BUS_MEM_RD, pcims_pkg::TERM_OK, 16'h1);
        chk_reads(1, 1'b1);
        run_cmd(pcims_pkg::OP_MEM_RD64, 32'h0000_0508, 64'h0, 4'h0, 16'h2,
            pcims_pkg::TERM_OK, 1'b1, pcims_pkg::BUS_MEM_RD, pcims_pkg::TERM_OK, 16'h2);
        chk_reads(2, 1'b1);
        $display("test mem64 finished");
    endtask

    task automatic t_io;
        run_cmd(pcims_pkg::OP_IO_WR, 32'h0000_0008, 64'h0000_00A5, 4'h0, 16'h2,
            pcims_pkg::TERM_OK, 1'b0, pcims_pkg::BUS_IO_WR, pcims_pkg::TERM_OK, 16'h1);
        chk_writes(1, 64'h0000_00A5, 1'b0);
        run_cmd(pcims_pkg::OP_IO_RD, 32'h0000_000C, 64'h0, 4'h0, 16'h1,
            pcims_pkg::TERM_OK, 1'b0, pcims_pkg::BUS_IO_RD, pcims_pkg::TERM_OK, 16'h1);
        chk_reads(1, 1'b0);
        $display("test io finished");
    endtask

    task automatic t_terms;
        pcims_pkg::pcims_term_t t;
        for (int i = 1; i < 5; i++)
        begin
            t = pcims_pkg::pcims_term_t'(i);
            run_cmd(pcims_pkg::OP_MEM_WR32, 32'h0000_0600, 64'h10, 4'h0, 16'h4, t, 1'b0,
                pcims_pkg::BUS_MEM_WR, t, (t == pcims_pkg::TERM_DISC) ? 16'h1 : 16'h0);
        end
        run_cmd(pcims_pkg::OP_MEM_WR32, 32'h0000_0700, 64'h20, 4'h0, 16'h2,
            pcims_pkg::TERM_OK, 1'b0, pcims_pkg::BUS_MEM_WR, pcims_pkg::TERM_OK, 16'h2);
        chk_writes(2, 64'h20, 1'b0);
        $display("test terminations finished");
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // 17 commands of under 40 cycles each; 5000 cycles leaves a wide margin.
    initial
    begin
        #50000;
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_config();
        t_mem32();
        t_mem64();
        t_io();
        t_terms();
        report_and_stop();
    end
endmodule
`default_nettype wire
